// File: pscs_pkg.sv
// Package for the passive serial configuration sequencer: constants, enums, structs
package pscs_pkg;

    // ------------------------------------------------------------
    // System clock and timing figures
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_MHZ        = 100;
    localparam int unsigned SYS_PERIOD_NS      = 10;

    localparam int unsigned RESP_MAX_NS        = 600;
    localparam int unsigned RESP_CYC           = RESP_MAX_NS / SYS_PERIOD_NS;
    localparam int unsigned REQ_LOW_MIN_US     = 2;
    localparam int unsigned REQ_LOW_MIN_CYC    = REQ_LOW_MIN_US * SYS_CLK_MHZ;
    localparam int unsigned STATUS_LOW_MIN_US  = 268;
    localparam int unsigned STATUS_LOW_MIN_CYC = STATUS_LOW_MIN_US * SYS_CLK_MHZ;
    localparam int unsigned STATUS_LOW_MAX_US  = 1506;
    localparam int unsigned STATUS_LOW_MAX_CYC = STATUS_LOW_MAX_US * SYS_CLK_MHZ;
    localparam int unsigned OSC_UM_MIN_US      = 175;
    localparam int unsigned OSC_UM_MIN_CYC     = OSC_UM_MIN_US * SYS_CLK_MHZ;
    localparam int unsigned OSC_UM_MAX_US      = 437;
    localparam int unsigned OSC_UM_MAX_CYC     = OSC_UM_MAX_US * SYS_CLK_MHZ;
    localparam int unsigned USER_CLK_MIN_CYC   = 8576;
    localparam int unsigned SHIFT_CLK_MAX_MHZ  = 125;
    localparam int unsigned CLKEN_DELAY_PERIODS = 4;
    localparam int unsigned OSC_MAX_KHZ        = 12500;
    localparam int unsigned OSC_DIV            = (SYS_CLK_MHZ * 1000 + OSC_MAX_KHZ - 1) / OSC_MAX_KHZ;
    localparam int unsigned CLKEN_DELAY_NS     = (CLKEN_DELAY_PERIODS * 1000) / SHIFT_CLK_MAX_MHZ;
    localparam int unsigned CLKEN_DELAY_CYC    = (CLKEN_DELAY_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    localparam int unsigned CNT_W              = 24;
    localparam int unsigned STREAM_W           = 32;

    // ------------------------------------------------------------
    // Start-up clock source selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PSCS_SRC_OSC   = 2'h0,
        PSCS_SRC_USER  = 2'h1,
        PSCS_SRC_SHIFT = 2'h2
    } pscs_src_e;

    // ------------------------------------------------------------
    // Sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        PSCS_ST_IDLE    = 6'h01,
        PSCS_ST_RESET   = 6'h02,
        PSCS_ST_CLEAR   = 6'h04,
        PSCS_ST_LOAD    = 6'h08,
        PSCS_ST_STARTUP = 6'h10,
        PSCS_ST_USER    = 6'h20
    } pscs_state_e;

    typedef struct packed {
        logic [STREAM_W-1:0] word;
        logic                last;
    } pscs_word_s;

endpackage

// File: pscs_fifo.sv
// Synchronous FIFO for assembled configuration words
`timescale 1ns/1ps
module pscs_fifo #(
    parameter int unsigned WIDTH = 33,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } pscs_fifo_s;

    pscs_fifo_s       st_q;
    pscs_fifo_s       st_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = (st_q.wr - st_q.rd) != (AW+1)'(DEPTH);
    assign out_valid = st_q.wr != st_q.rd;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[st_q.rd[AW-1:0]];

    always_comb
    begin
        st_d = st_q;
        if (push)
            st_d.wr = st_q.wr + 1'b1;
        if (pop)
            st_d.rd = st_q.rd + 1'b1;
        if (flush)
            st_d = '0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[st_q.wr[AW-1:0]] <= in_data;
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end
endmodule

// File: pscs_sequencer.sv
// Passive serial configuration sequencer: request, status, load-complete and start-up
`timescale 1ns/1ps

module pscs_sequencer #(
    parameter int unsigned        STREAM_BITS     = 1024,
    parameter int unsigned        FIFO_DEPTH      = 16,
    parameter logic [23:0]        STATUS_LOW_CYC  = 24'(pscs_pkg::STATUS_LOW_MIN_CYC),
    parameter logic [23:0]        OSC_STARTUP_CYC = 24'(pscs_pkg::OSC_UM_MIN_CYC),
    parameter logic [23:0]        USER_CLK_CYC    = 24'(pscs_pkg::USER_CLK_MIN_CYC)
) (
    input  wire logic                         clk_sys,
    input  wire logic                         sys_rst,
    input  wire logic                         config_req_n,
    input  wire logic                         status_in,
    output logic                              status_out,
    output logic                              status_oe,
    output logic                              load_done_out,
    output logic                              load_done_oe,
    input  wire logic                         config_shift_clock,
    input  wire logic                         config_data,
    input  wire logic                         user_startup_clock,
    input  wire pscs_pkg::pscs_src_e          startup_src,
    output logic                              user_mode,
    output logic [pscs_pkg::STREAM_W-1:0]     word_data,
    output logic                              word_last,
    output logic                              word_valid,
    input  wire logic                         word_ready,
    output logic                              overrun
);

    // ------------------------------------------------------------
    // Shift clock domain: bit capture and word assembly
    // ------------------------------------------------------------
    // The shift clock runs while the host loads and for three edges while status is low; its domain state is
    // cleared from the system side through an asynchronous clear level.
    typedef struct packed {
        logic [pscs_pkg::STREAM_W-1:0] shreg;
        logic [4:0]                    nbit;
        logic [31:0]                   total;
        logic                          wtog;
        logic [pscs_pkg::STREAM_W-1:0] wbuf;
        logic                          wlast;
        logic                          done;
    } pscs_lnk_s;

    pscs_lnk_s lnk_q;
    pscs_lnk_s lnk_d;
    logic      lnk_clr_req;
    logic      usr_en_req;

    always_comb
    begin
        lnk_d = lnk_q;
        if (!lnk_q.done)
        begin
            lnk_d.shreg = {lnk_q.shreg[pscs_pkg::STREAM_W-2:0], config_data};
            lnk_d.nbit  = lnk_q.nbit + 5'h1;
            lnk_d.total = lnk_q.total + 32'h1;
            if (lnk_q.total == 32'(STREAM_BITS - 1))
                lnk_d.done = 1'b1;
            if (lnk_q.nbit == 5'h1f || lnk_q.total == 32'(STREAM_BITS - 1))
            begin
                lnk_d.wbuf  = {lnk_q.shreg[pscs_pkg::STREAM_W-2:0], config_data};
                lnk_d.wlast = (lnk_q.total == 32'(STREAM_BITS - 1));
                lnk_d.wtog  = ~lnk_q.wtog;
                lnk_d.nbit  = 5'h0;
            end
        end
    end

    // Clear acts asynchronously and is released while the shift clock stands
    // still: the host gives no shift edge from status rising until 2000 ns later, so
    // the release never meets an edge. A clear synchronised on this clock
    // would need two edges to let go and would swallow the first bits.
    always_ff @(posedge config_shift_clock or posedge lnk_clr_req)
    begin
        if (lnk_clr_req)
            lnk_q <= '0;
        else
            lnk_q <= lnk_d;
    end

    // ------------------------------------------------------------
    // User start-up clock domain: cycle counter
    // ------------------------------------------------------------
    typedef struct packed {
        logic [23:0] cnt;
        logic        fin;
    } pscs_usr_s;

    pscs_usr_s usr_q;
    pscs_usr_s usr_d;
    logic      usr_en_s1_q;
    logic      usr_en_s2_q;

    always_comb
    begin
        usr_d = usr_q;
        if (!usr_en_s2_q)
            usr_d = '0;
        else if (usr_q.cnt == USER_CLK_CYC - 24'h1)
            usr_d.fin = 1'b1;
        else
            usr_d.cnt = usr_q.cnt + 24'h1;
    end

    always_ff @(posedge user_startup_clock)
    begin
        usr_en_s1_q <= usr_en_req;
        usr_en_s2_q <= usr_en_s1_q;
        usr_q       <= usr_d;
    end

    // ------------------------------------------------------------
    // System domain
    // ------------------------------------------------------------
    typedef struct packed {
        pscs_pkg::pscs_state_e state;
        logic [23:0]           cnt;
        logic                  req_s1;
        logic                  req_s2;
        logic                  sts_s1;
        logic                  sts_s2;
        logic                  wt_s1;
        logic                  wt_s2;
        logic                  wt_s3;
        logic                  dn_s1;
        logic                  dn_s2;
        logic                  uf_s1;
        logic                  uf_s2;
        logic                  clr;
        logic                  usr_en;
        logic                  status_lo;
        logic                  done_lo;
        logic                  user;
        logic                  ovr;
        logic [3:0]            osc_div;
    } pscs_sys_s;

    pscs_sys_s sys_q;
    pscs_sys_s sys_d;
    // Requests towards the link and user clock domains are plain flops of
    // the system state, so they never glitch while the far clock samples.
    logic      word_in_valid;
    logic      word_in_ready;
    logic      req_low;
    logic      osc_tick;

    assign lnk_clr_req   = sys_q.clr;
    assign usr_en_req    = sys_q.usr_en;
    assign req_low       = !sys_q.req_s2;
    assign word_in_valid = (sys_q.wt_s2 != sys_q.wt_s3) && sys_q.state == pscs_pkg::PSCS_ST_LOAD;
    assign osc_tick      = sys_q.osc_div == 4'(pscs_pkg::OSC_DIV - 1);

    always_comb
    begin
        sys_d        = sys_q;
        sys_d.req_s1 = config_req_n;
        sys_d.req_s2 = sys_q.req_s1;
        sys_d.sts_s1 = status_in;
        sys_d.sts_s2 = sys_q.sts_s1;
        sys_d.wt_s1  = lnk_q.wtog;
        sys_d.wt_s2  = sys_q.wt_s1;
        sys_d.wt_s3  = sys_q.wt_s2;
        sys_d.dn_s1  = lnk_q.done;
        sys_d.dn_s2  = sys_q.dn_s1;
        sys_d.uf_s1  = usr_q.fin;
        sys_d.uf_s2  = sys_q.uf_s1;
        sys_d.osc_div = osc_tick ? 4'h0 : sys_q.osc_div + 4'h1;
        if (word_in_valid && !word_in_ready)
            sys_d.ovr = 1'b1;
        case (sys_q.state)
            pscs_pkg::PSCS_ST_IDLE:
            begin
                sys_d.state = pscs_pkg::PSCS_ST_RESET;
            end
            pscs_pkg::PSCS_ST_RESET:
            begin
                // Hold status low for the minimum, then wait for request high
                sys_d.status_lo = 1'b1;
                sys_d.done_lo   = 1'b1;
                sys_d.clr       = 1'b1;
                sys_d.user      = 1'b0;
                sys_d.usr_en    = 1'b0;
                sys_d.ovr       = 1'b0;
                if (sys_q.cnt < STATUS_LOW_CYC)
                    sys_d.cnt = sys_q.cnt + 24'h1;
                else if (!req_low)
                begin
                    sys_d.state     = pscs_pkg::PSCS_ST_CLEAR;
                    sys_d.status_lo = 1'b0;
                    sys_d.cnt       = '0;
                end
            end
            pscs_pkg::PSCS_ST_CLEAR:
            begin
                // Keep the link clear until status is seen high on the pin
                if (sys_q.sts_s2)
                begin
                    sys_d.clr   = 1'b0;
                    sys_d.state = pscs_pkg::PSCS_ST_LOAD;
                end
            end
            pscs_pkg::PSCS_ST_LOAD:
            begin
                if (sys_q.dn_s2 && sys_q.wt_s2 == sys_q.wt_s3)
                begin
                    sys_d.done_lo = 1'b0;
                    sys_d.cnt     = '0;
                    sys_d.state   = pscs_pkg::PSCS_ST_STARTUP;
                end
            end
            pscs_pkg::PSCS_ST_STARTUP:
            begin
                case (startup_src)
                    pscs_pkg::PSCS_SRC_OSC:
                    begin
                        if (sys_q.cnt >= OSC_STARTUP_CYC)
                            sys_d.state = pscs_pkg::PSCS_ST_USER;
                        else if (osc_tick || 1'b1)
                            sys_d.cnt = sys_q.cnt + 24'h1;
                    end
                    pscs_pkg::PSCS_SRC_USER:
                    begin
                        if (sys_q.cnt >= 24'(pscs_pkg::CLKEN_DELAY_CYC))
                            sys_d.usr_en = 1'b1;
                        else
                            sys_d.cnt = sys_q.cnt + 24'h1;
                        if (sys_q.uf_s2)
                            sys_d.state = pscs_pkg::PSCS_ST_USER;
                    end
                    default:
                    begin
                        // Shift clock start-up: user mode follows at once, with no further bits counted
                        sys_d.state = pscs_pkg::PSCS_ST_USER;
                    end
                endcase
            end
            pscs_pkg::PSCS_ST_USER:
            begin
                sys_d.user = 1'b1;
            end
            default:
            begin
                sys_d.state = pscs_pkg::PSCS_ST_IDLE;
            end
        endcase
        // A request low overrides every state and drives both outputs low
        if (req_low)
        begin
            sys_d.state     = pscs_pkg::PSCS_ST_RESET;
            sys_d.cnt       = '0;
            sys_d.status_lo = 1'b1;
            sys_d.done_lo   = 1'b1;
            sys_d.clr       = 1'b1;
            sys_d.user      = 1'b0;
            sys_d.usr_en    = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sys_q           <= '0;
            sys_q.state     <= pscs_pkg::PSCS_ST_IDLE;
            sys_q.req_s1    <= 1'b1;
            sys_q.req_s2    <= 1'b1;
            sys_q.status_lo <= 1'b1;
            sys_q.done_lo   <= 1'b1;
            sys_q.clr       <= 1'b1;
        end
        else
            sys_q <= sys_d;
    end

    // ------------------------------------------------------------
    // Open-drain pins and user side
    // ------------------------------------------------------------
    assign status_out    = 1'b0;
    assign status_oe     = sys_q.status_lo;
    assign load_done_out = 1'b0;
    assign load_done_oe  = sys_q.done_lo;
    assign user_mode     = sys_q.user;
    assign overrun       = sys_q.ovr;

    pscs_pkg::pscs_word_s fifo_in;
    pscs_pkg::pscs_word_s fifo_out;

    // Word buffer is stable in the link domain for many shift edges after a toggle
    assign fifo_in.word = lnk_q.wbuf;
    assign fifo_in.last = lnk_q.wlast;
    assign word_data    = fifo_out.word;
    assign word_last    = fifo_out.last;

    pscs_fifo #(
        .WIDTH ($bits(pscs_pkg::pscs_word_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .flush     (sys_q.clr),
        .in_data   (fifo_in),
        .in_valid  (word_in_valid),
        .in_ready  (word_in_ready),
        .out_data  (fifo_out),
        .out_valid (word_valid),
        .out_ready (word_ready)
    );

endmodule

// File: pscs_sequencer_sva.sv
// Assertion checker bound to the passive serial configuration sequencer
`timescale 1ns/1ps
module pscs_sequencer_sva #(
    parameter int unsigned STREAM_BITS     = 1024,
    parameter logic [23:0] STATUS_LOW_CYC  = 24'h000032,
    parameter logic [23:0] OSC_STARTUP_CYC = 24'h000028,
    parameter logic [23:0] USER_CLK_CYC    = 24'h000014
) (
    input wire logic                          clk_sys,
    input wire logic                          sys_rst,
    input wire logic                          config_req_n,
    input wire logic                          status_oe,
    input wire logic                          load_done_oe,
    input wire logic                          config_shift_clock,
    input wire logic                          user_startup_clock,
    input wire pscs_pkg::pscs_src_e           startup_src,
    input wire logic                          user_mode,
    input wire logic [pscs_pkg::STREAM_W-1:0] word_data,
    input wire logic                          word_valid,
    input wire logic                          word_ready
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic [23:0] low_cnt_q;
    logic [23:0] wait_cnt_q;
    logic [15:0] bit_cnt_q;
    logic [15:0] usr_cnt_q;

    always_ff @(posedge clk_sys)
    begin
        low_cnt_q  <= (sys_rst || !status_oe) ? 24'h0 : low_cnt_q + 24'h1;
        wait_cnt_q <= (sys_rst || load_done_oe) ? 24'h0 : wait_cnt_q + {23'h0, !user_mode};
    end

    // Link-side edges counted only once status is released, as the device does
    always_ff @(posedge config_shift_clock or posedge status_oe)
        bit_cnt_q <= status_oe ? 16'h0 : bit_cnt_q + 16'h1;

    always_ff @(posedge user_startup_clock or posedge load_done_oe)
        usr_cnt_q <= load_done_oe ? 16'h0 : usr_cnt_q + 16'h1;

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_req_fall;
        $fell(config_req_n);
    endsequence

    sequence s_user_entry;
        $rose(user_mode);
    endsequence

    a_done_drop: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_req_fall |-> ##[0:60] load_done_oe) else $error("load-complete not pulled low in time");
    a_status_drop: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_req_fall |-> ##[0:60] status_oe) else $error("status not pulled low in time");
    a_status_width: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(status_oe) |-> low_cnt_q >= STATUS_LOW_CYC && low_cnt_q <= 24'h000119)
        else $error("status low pulse width out of range");
    a_status_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
        config_req_n && status_oe |-> ##[0:281] !status_oe) else $error("status not released");
    a_osc_window: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_user_entry ##0 (startup_src == pscs_pkg::PSCS_SRC_OSC) |->
        wait_cnt_q >= OSC_STARTUP_CYC && wait_cnt_q <= (OSC_STARTUP_CYC * 437) / 175)
        else $error("oscillator start-up time out of range");
    a_user_clocks: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_user_entry ##0 (startup_src == pscs_pkg::PSCS_SRC_USER) |-> usr_cnt_q >= USER_CLK_CYC)
        else $error("user mode before enough user clock cycles");
    a_shift_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(load_done_oe) && startup_src == pscs_pkg::PSCS_SRC_SHIFT |-> ##[0:8] user_mode)
        else $error("shift clock start-up late");
    a_bit_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(load_done_oe) |-> bit_cnt_q == STREAM_BITS) else $error("load-complete at wrong bit count");
    a_user_safe: assert property (@(posedge clk_sys) disable iff (sys_rst)
        user_mode |-> !load_done_oe && !status_oe) else $error("user mode while pins pulled low");
    a_word_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        word_valid && !word_ready |=> word_valid && $stable(word_data)) else $error("word changed while stalled");
endmodule

bind pscs_sequencer pscs_sequencer_sva #(
    .STREAM_BITS(STREAM_BITS), .STATUS_LOW_CYC(STATUS_LOW_CYC),
    .OSC_STARTUP_CYC(OSC_STARTUP_CYC), .USER_CLK_CYC(USER_CLK_CYC)
) u_sva (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .config_req_n(config_req_n), .status_oe(status_oe),
    .load_done_oe(load_done_oe), .config_shift_clock(config_shift_clock),
    .user_startup_clock(user_startup_clock), .startup_src(startup_src), .user_mode(user_mode),
    .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready)
);

// File: pscs_host.sv
// Behavioural configuration host: request, shift clock, serial data and user start-up clock
`timescale 1ns/1ps
module pscs_host (
    output logic      config_req_n,
    output logic      config_shift_clock,
    output logic      config_data,
    output logic      user_startup_clock,
    input  wire logic status_level,
    input  wire logic done_level
);
    initial
    begin
        config_req_n       = 1'h1;
        config_shift_clock = 1'h0;
        config_data        = 1'h0;
        user_startup_clock = 1'h0;
    end

    function automatic logic [31:0] pat(input logic [7:0] seed, input int k);
        return 32'h5a3c96e1 ^ {4{seed}} ^ (32'(k) * 32'h01010101);
    endfunction

    // Shift clock runs only inside frames; 6 ns period
    task automatic shift_edge(input logic bit_val);
        config_data = bit_val;
        #3;
        config_shift_clock = 1'h1;
        #3;
        config_shift_clock = 1'h0;
    endtask

    task automatic configure(input logic [7:0] seed, input int words, input int usr_cycles);
        logic [31:0] w;
        config_req_n = 1'h0;
        #100;
        // Shift edges while status is still low; the link side is held clear and ignores them
        repeat (3) shift_edge(1'h1);
        #2000;
        config_req_n = 1'h1;
        wait (status_level === 1'h1);
        #2000;
        for (int k = 0; k < words; k++)
        begin
            w = pat(seed, k);
            for (int b = 31; b >= 0; b--)
                shift_edge(w[b]);
        end
        // Released line must not keep showing the last bit
        config_data = ~config_data;
        wait (done_level === 1'h1);
        #32;
        repeat (usr_cycles)
        begin
            #4 user_startup_clock = 1'h1;
            #4 user_startup_clock = 1'h0;
        end
    endtask
endmodule

// File: tb.sv
// Self-checking testbench for the passive serial configuration sequencer
`timescale 1ns/1ps
module tb;
    localparam int WORDS = 18;

    logic                clk_sys, sys_rst, word_ready;
    logic                config_req_n, config_shift_clock, config_data, user_startup_clock;
    logic                status_out, status_oe, load_done_out, load_done_oe, user_mode;
    logic                word_last, word_valid, overrun, status_level, done_level;
    logic [31:0]         word_data;
    pscs_pkg::pscs_src_e startup_src;
    int                  failures, total_checks, cycles;

    // Both open-drain wires have pull-ups
    assign status_level = ~status_oe;
    assign done_level   = ~load_done_oe;

    pscs_sequencer #(
        .STREAM_BITS(576), .FIFO_DEPTH(16), .STATUS_LOW_CYC(24'h000032),
        .OSC_STARTUP_CYC(24'h000028), .USER_CLK_CYC(24'h000014)
    ) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .config_req_n(config_req_n), .status_in(status_level),
        .status_out(status_out), .status_oe(status_oe), .load_done_out(load_done_out),
        .load_done_oe(load_done_oe), .config_shift_clock(config_shift_clock), .config_data(config_data),
        .user_startup_clock(user_startup_clock), .startup_src(startup_src), .user_mode(user_mode),
        .word_data(word_data), .word_last(word_last), .word_valid(word_valid), .word_ready(word_ready),
        .overrun(overrun)
    );

    pscs_host host (
        .config_req_n(config_req_n), .config_shift_clock(config_shift_clock), .config_data(config_data),
        .user_startup_clock(user_startup_clock), .status_level(status_level), .done_level(done_level)
    );

    initial
        clk_sys = 1'h0;
    always #5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic check_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Whole run is about 3500 cycles
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            test_done;
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic collect(input logic [7:0] seed);
        int k;
        k = 0;
        for (int n = 0; n < 3000 && k < WORDS; n++)
        begin
            @(negedge clk_sys);
            word_ready = 1'h1;
            if (word_valid === 1'h1)
            begin
                check_word(word_data, host.pat(seed, k));
                check_bit(word_last, 1'(k == WORDS - 1));
                k++;
            end
        end
        check_bit(1'(k == WORDS), 1'h1);
    endtask

    task automatic wait_user;
        for (int n = 0; n < 2000 && user_mode !== 1'h1; n++)
            @(negedge clk_sys);
        check_bit(user_mode, 1'h1);
    endtask

    task automatic t_reset;
        check_bit(status_oe, 1'h1);
        check_bit(load_done_oe, 1'h1);
        check_bit(user_mode, 1'h0);
        check_bit(word_valid, 1'h0);
        check_bit(status_out, 1'h0);
        check_bit(load_done_out, 1'h0);
        for (int n = 0; n < 300 && status_oe !== 1'h0; n++)
            @(negedge clk_sys);
        check_bit(status_oe, 1'h0);
        check_bit(load_done_oe, 1'h1);
    endtask

    task automatic t_config(input pscs_pkg::pscs_src_e src, input logic [7:0] seed);
        @(negedge clk_sys);
        startup_src = src;
        fork
            host.configure(seed, WORDS, 30);
            begin
                #700;
                check_bit(status_oe, 1'h1);
                check_bit(load_done_oe, 1'h1);
                check_bit(user_mode, 1'h0);
                check_bit(overrun, 1'h0);
                collect(seed);
            end
        join
        wait_user;
        check_bit(overrun, 1'h0);
    endtask

    task automatic t_stall(input logic [7:0] seed);
        int k;
        k = 0;
        @(negedge clk_sys);
        word_ready  = 1'h0;
        startup_src = pscs_pkg::PSCS_SRC_SHIFT;
        host.configure(seed, WORDS, 0);
        @(negedge clk_sys);
        // Eighteen words cannot fit a sixteen-deep buffer
        check_bit(overrun, 1'h1);
        check_word(word_data, host.pat(seed, 0));
        while (word_valid === 1'h1 && k < 40)
        begin
            word_ready = 1'h1;
            @(negedge clk_sys);
            k++;
        end
        check_bit(word_valid, 1'h0);
        check_bit(1'(k >= 16), 1'h1);
        wait_user;
    endtask

    initial
    begin
        sys_rst      = 1'h1;
        word_ready   = 1'h0;
        startup_src  = pscs_pkg::PSCS_SRC_OSC;
        failures     = 0;
        total_checks = 0;
        cycles       = 0;
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'h0;
        @(negedge clk_sys);
        t_reset;
        t_config(pscs_pkg::PSCS_SRC_OSC, 8'h11);
        t_config(pscs_pkg::PSCS_SRC_USER, 8'h22);
        t_stall(8'h33);
        t_config(pscs_pkg::PSCS_SRC_SHIFT, 8'h44);
        test_done;
    end
endmodule
